// ---- cafec_top.sv ----
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "cafec_map.svh"
// How it works
// R1: Only identifier bits ten to three are compared.
// R2: Mask zero means relevant, one means ignored.
// R3: Accept only when all relevant bits match.
// R4: Rejected frames never reach any receive storage.
// R5: Four error counters, each counts its event.
// R6: Full receive buffer on store bumps overflow.
// R7: Full holding buffer is overwritten, bumps overrun.
// R8: Every detected bus error bumps bus-error counter.
// R9: Bus-off bumps its counter and self-resets controller.
// R10: Sixteen-bit completion status, zero means success.
// R11: Reset clears counters and code and sets mask to all ones; code and mask hold until written.
module cafec_top
    import cafec_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire cafec_bus_s               bus_i,
    output logic [`CAFEC_DATA_W-1:0]      rd_data_o,
    input  wire cafec_frame_s             rx_frame_i,
    input  wire logic                     rx_valid_i,
    input  wire cafec_evt_s               evt_i,
    output logic                          irq_o,
    output logic                          ctl_rst_o
);

    cafec_state_s             r;
    cafec_state_s             s;
    logic                     acc_w;
    logic                     pop_w;
    cafec_frame_s             head_w;
    logic [`CAFEC_DATA_W-1:0] rx_stat_w;
    cafec_irq_t               evts;

    // The mask bit forces a position to match, so only relevant bits can reject.
    assign acc_w = ((rx_frame_i.id[`CAFEC_ID_W-1 -: `CAFEC_FLT_W] ^ r.code) & ~r.mask)
                   == '0; // R1 R2 R3

    assign pop_w  = bus_i.wr && (bus_i.addr == `CAFEC_OFF_RX_POP);
    assign head_w = r.fifo[r.rd_ptr];

    // Layout: id, spare bit, length, fill count, holding flag, zero fill.
    assign rx_stat_w = {12'h000, r.hold_full, r.count, head_w.dlc, 1'b0, head_w.id};

    always_comb begin
        s         = r;
        evts      = '0;
        s.ctl_rst = 1'b0;
        s.rdata   = '0;

        if (bus_i.wr) begin
            s.cmd_stat = `CAFEC_ST_OK; // R10
            case (bus_i.addr)
                `CAFEC_OFF_CODE: begin
                    s.code = bus_i.wdata[`CAFEC_FLT_W-1:0]; // R11
                end
                `CAFEC_OFF_MASK: begin
                    s.mask = bus_i.wdata[`CAFEC_FLT_W-1:0]; // R11
                end
                `CAFEC_OFF_CTRL: begin
                    s.xfer_en = bus_i.wdata[`CAFEC_CTRL_XFER_BIT];
                end
                `CAFEC_OFF_IRQ_MASK: begin
                    s.irq_mask = bus_i.wdata[`CAFEC_IRQ_W-1:0];
                end
                `CAFEC_OFF_RX_POP: begin
                    if (r.count == '0) begin
                        s.cmd_stat = `CAFEC_ST_EMPTY; // R10
                    end else begin
                        s.rd_ptr = r.rd_ptr + cafec_ptr_t'(1);
                        s.count  = r.count - cafec_fcnt_t'(1);
                    end
                end
                default: begin
                    s.cmd_stat = `CAFEC_ST_BADADDR; // R10
                end
            endcase
        end

        if (bus_i.rd) begin
            s.cmd_stat = `CAFEC_ST_OK; // R10
            case (bus_i.addr)
                `CAFEC_OFF_CODE: begin
                    s.rdata = `CAFEC_DATA_W'(r.code);
                end
                `CAFEC_OFF_MASK: begin
                    s.rdata = `CAFEC_DATA_W'(r.mask);
                end
                `CAFEC_OFF_CTRL: begin
                    s.rdata = `CAFEC_DATA_W'(r.xfer_en);
                end
                `CAFEC_OFF_RX_STAT: begin
                    s.rdata = rx_stat_w;
                end
                `CAFEC_OFF_RX_DLO: begin
                    s.rdata = head_w.data[`CAFEC_HALF_W-1:0];
                end
                `CAFEC_OFF_RX_DHI: begin
                    s.rdata = head_w.data[`CAFEC_PAY_W-1:`CAFEC_HALF_W];
                end
                `CAFEC_OFF_CNT_OVF: begin
                    s.rdata = `CAFEC_DATA_W'(r.cnt.ovf);
                end
                `CAFEC_OFF_CNT_OVR: begin
                    s.rdata = `CAFEC_DATA_W'(r.cnt.ovr);
                end
                `CAFEC_OFF_CNT_BERR: begin
                    s.rdata = `CAFEC_DATA_W'(r.cnt.berr);
                end
                `CAFEC_OFF_CNT_BOFF: begin
                    s.rdata = `CAFEC_DATA_W'(r.cnt.boff);
                end
                `CAFEC_OFF_IRQ_STAT: begin
                    s.rdata    = `CAFEC_DATA_W'(r.irq_stat);
                    s.irq_stat = '0;
                end
                `CAFEC_OFF_IRQ_MASK: begin
                    s.rdata = `CAFEC_DATA_W'(r.irq_mask);
                end
                `CAFEC_OFF_CMD_STAT: begin
                    s.rdata    = `CAFEC_DATA_W'(r.cmd_stat);
                    s.cmd_stat = r.cmd_stat;
                end
                default: begin
                    s.cmd_stat = `CAFEC_ST_BADADDR; // R10
                end
            endcase
        end

        // A pop in the same cycle frees a place first, so it never counts as overflow.
        if (r.hold_full && r.xfer_en) begin
            s.fifo[r.wr_ptr] = r.hold;
            s.wr_ptr         = r.wr_ptr + cafec_ptr_t'(1);
            s.hold_full      = 1'b0;
            evts[`CAFEC_IRQ_RX] = 1'b1;
            if (s.count == cafec_fcnt_t'(`CAFEC_FIFO_D)) begin
                s.rd_ptr  = s.rd_ptr + cafec_ptr_t'(1); // R6
                s.cnt.ovf = r.cnt.ovf + cafec_ecnt_t'(1); // R6 R5
                evts[`CAFEC_IRQ_OVF] = 1'b1;
            end else begin
                s.count = s.count + cafec_fcnt_t'(1);
            end
        end

        if (rx_valid_i && acc_w) begin // R4
            if (s.hold_full) begin
                s.cnt.ovr = r.cnt.ovr + cafec_ecnt_t'(1); // R7 R5
                evts[`CAFEC_IRQ_OVR] = 1'b1;
            end
            s.hold      = rx_frame_i; // R7
            s.hold_full = 1'b1;
        end

        if (evt_i.bus_err) begin
            s.cnt.berr = r.cnt.berr + cafec_ecnt_t'(1); // R8 R5
            evts[`CAFEC_IRQ_BERR] = 1'b1;
        end

        // The controller restart discards a held frame that is not moved to the receive buffer in the same cycle.
        if (evt_i.bus_off) begin
            s.cnt.boff  = r.cnt.boff + cafec_ecnt_t'(1); // R9 R5
            s.ctl_rst   = 1'b1; // R9
            s.hold_full = 1'b0;
            evts[`CAFEC_IRQ_BOFF] = 1'b1;
        end

        // A new event wins over the clear caused by a status read.
        s.irq_stat = s.irq_stat | evts;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r         <= '0; // R11
            r.mask    <= `CAFEC_MASK_RST;
            r.xfer_en <= `CAFEC_XFER_RST;
        end else begin
            r <= s;
        end
    end

    assign rd_data_o = r.rdata;
    assign irq_o     = |(r.irq_stat & r.irq_mask);
    assign ctl_rst_o = r.ctl_rst;

    a_low_bits_free: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        rx_valid_i && (r.mask == '0)
        && (rx_frame_i.id[`CAFEC_ID_W-1 -: `CAFEC_FLT_W] == r.code) |-> acc_w)
        else $error("Low identifier bits affected acceptance.");

    a_mask_ignores_all: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        rx_valid_i && (&r.mask) |-> acc_w)
        else $error("All-ones mask did not accept.");

    a_mismatch_rejects: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        rx_valid_i && (r.mask == '0)
        && (rx_frame_i.id[`CAFEC_ID_W-1 -: `CAFEC_FLT_W] != r.code) |-> !acc_w)
        else $error("Mismatching identifier was accepted.");

    a_reject_not_held: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        rx_valid_i && !acc_w && !r.hold_full |=> !r.hold_full)
        else $error("Rejected frame entered the holding buffer.");

    a_accept_held: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        rx_valid_i && acc_w && !evt_i.bus_off
        |=> r.hold_full && (r.hold.id == $past(rx_frame_i.id)))
        else $error("Accepted frame was not held.");

    a_berr_stable: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        !evt_i.bus_err |=> $stable(r.cnt.berr))
        else $error("Bus-error counter moved without an event.");

    a_overflow_count: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        r.hold_full && r.xfer_en && !pop_w && (r.count == cafec_fcnt_t'(`CAFEC_FIFO_D))
        |=> (r.cnt.ovf == $past(r.cnt.ovf) + cafec_ecnt_t'(1))
        && (r.count == cafec_fcnt_t'(`CAFEC_FIFO_D)))
        else $error("Overflow not counted on full receive buffer.");

    a_overrun_count: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        rx_valid_i && acc_w && r.hold_full && !r.xfer_en && !evt_i.bus_off
        |=> (r.cnt.ovr == $past(r.cnt.ovr) + cafec_ecnt_t'(1))
        && (r.hold.data == $past(rx_frame_i.data)))
        else $error("Overrun not counted or holding buffer not replaced.");

    a_berr_count: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        evt_i.bus_err |=> r.cnt.berr == $past(r.cnt.berr) + cafec_ecnt_t'(1))
        else $error("Bus error not counted.");

    a_busoff_restart: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        evt_i.bus_off |=> ctl_rst_o && !r.hold_full
        && (r.cnt.boff == $past(r.cnt.boff) + cafec_ecnt_t'(1)))
        else $error("Bus-off did not count or restart the controller.");

    a_status_badaddr: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        bus_i.wr && (bus_i.addr == `CAFEC_OFF_CNT_OVF) |=> r.cmd_stat == `CAFEC_ST_BADADDR)
        else $error("Write to a read-only offset reported success.");

    a_status_empty: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        pop_w && (r.count == '0) |=> (r.cmd_stat == `CAFEC_ST_EMPTY) && $stable(r.rd_ptr))
        else $error("Pop of empty buffer not reported.");

    a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        $past(rst_i) |-> (r.cnt == '0) && (r.mask == `CAFEC_MASK_RST))
        else $error("Counters not cleared by reset.");

    a_code_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        !(bus_i.wr && (bus_i.addr == `CAFEC_OFF_CODE)) |=> $stable(r.code))
        else $error("Acceptance code changed without a write.");

    a_mask_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        !(bus_i.wr && (bus_i.addr == `CAFEC_OFF_MASK)) |=> $stable(r.mask))
        else $error("Acceptance mask changed without a write.");

    a_berr_irq_set: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        evt_i.bus_err |=> r.irq_stat[`CAFEC_IRQ_BERR])
        else $error("Bus error did not set its status bit.");

    a_boff_irq_set: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        evt_i.bus_off |=> r.irq_stat[`CAFEC_IRQ_BOFF])
        else $error("Bus-off did not set its status bit.");

    a_ovf_stable: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        !(r.hold_full && r.xfer_en) |=> $stable(r.cnt.ovf))
        else $error("Overflow counter moved without a store.");

    a_ovr_stable: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        !(rx_valid_i && acc_w) |=> $stable(r.cnt.ovr))
        else $error("Overrun counter moved without an accepted frame.");

    a_boff_stable: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        !evt_i.bus_off |=> $stable(r.cnt.boff))
        else $error("Bus-off counter moved without an event.");

    a_restart_cause: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        ctl_rst_o |-> $past(evt_i.bus_off))
        else $error("Controller restart without a bus-off.");

    a_restart_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        !evt_i.bus_off |=> !ctl_rst_o)
        else $error("Controller restart pulse without a bus-off.");

    a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        r.count <= cafec_fcnt_t'(`CAFEC_FIFO_D))
        else $error("Receive fill count beyond its depth.");

    a_store_counts: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        r.hold_full && r.xfer_en && !pop_w && (r.count < cafec_fcnt_t'(`CAFEC_FIFO_D))
        |=> r.count == $past(r.count) + cafec_fcnt_t'(1))
        else $error("Stored frame did not raise the fill count.");

    a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        !bus_i.rd |=> rd_data_o == '0)
        else $error("Read data shown without a read.");

    a_status_kept: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        bus_i.rd && !bus_i.wr && (bus_i.addr == `CAFEC_OFF_CMD_STAT) |=> $stable(r.cmd_stat))
        else $error("Reading the status changed it.");

    a_status_ok: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        bus_i.wr && (bus_i.addr == `CAFEC_OFF_CODE) |=> r.cmd_stat == `CAFEC_ST_OK)
        else $error("Write to the code register did not report success.");

    a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        bus_i.rd && (bus_i.addr == `CAFEC_OFF_IRQ_STAT) && !evt_i.bus_err && !evt_i.bus_off
        && !(rx_valid_i && acc_w) && !(r.hold_full && r.xfer_en) |=> r.irq_stat == '0)
        else $error("Status read did not clear the event bits.");

endmodule : cafec_top

// ---- cafec_map.svh ----
`ifndef CAFEC_MAP_SVH
`define CAFEC_MAP_SVH

`define CAFEC_ID_W          11
`define CAFEC_DLC_W         4
`define CAFEC_PAY_W         64
`define CAFEC_FLT_W         8
`define CAFEC_CNT_W         16
`define CAFEC_ST_W          16
`define CAFEC_ADDR_W        8
`define CAFEC_DATA_W        32
`define CAFEC_HALF_W        32
`define CAFEC_FIFO_D        4
`define CAFEC_PTR_W         2
`define CAFEC_FCNT_W        3
`define CAFEC_IRQ_W         5

`define CAFEC_OFF_CODE      8'h00
`define CAFEC_OFF_MASK      8'h04
`define CAFEC_OFF_CTRL      8'h08
`define CAFEC_OFF_RX_STAT   8'h0C
`define CAFEC_OFF_RX_DLO    8'h10
`define CAFEC_OFF_RX_DHI    8'h14
`define CAFEC_OFF_RX_POP    8'h18
`define CAFEC_OFF_CNT_OVF   8'h1C
`define CAFEC_OFF_CNT_OVR   8'h20
`define CAFEC_OFF_CNT_BERR  8'h24
`define CAFEC_OFF_CNT_BOFF  8'h28
`define CAFEC_OFF_IRQ_STAT  8'h2C
`define CAFEC_OFF_IRQ_MASK  8'h30
`define CAFEC_OFF_CMD_STAT  8'h34

`define CAFEC_CTRL_XFER_BIT 0
`define CAFEC_IRQ_RX        0
`define CAFEC_IRQ_OVF       1
`define CAFEC_IRQ_OVR       2
`define CAFEC_IRQ_BERR      3
`define CAFEC_IRQ_BOFF      4

`define CAFEC_MASK_RST      8'hFF
`define CAFEC_XFER_RST      1'h1
`define CAFEC_ST_OK         16'h0000
`define CAFEC_ST_EMPTY      16'h0001
`define CAFEC_ST_BADADDR    16'h0002

`endif

// ---- cafec_pkg.sv ----
`include "cafec_map.svh"

package cafec_pkg;

    typedef logic [`CAFEC_PTR_W-1:0]  cafec_ptr_t;
    typedef logic [`CAFEC_FCNT_W-1:0] cafec_fcnt_t;
    typedef logic [`CAFEC_CNT_W-1:0]  cafec_ecnt_t;
    typedef logic [`CAFEC_IRQ_W-1:0]  cafec_irq_t;

    typedef struct packed {
        logic [`CAFEC_ID_W-1:0]  id;
        logic [`CAFEC_DLC_W-1:0] dlc;
        logic [`CAFEC_PAY_W-1:0] data;
    } cafec_frame_s;

    typedef struct packed {
        logic [`CAFEC_ADDR_W-1:0] addr;
        logic [`CAFEC_DATA_W-1:0] wdata;
        logic                     wr;
        logic                     rd;
    } cafec_bus_s;

    typedef struct packed {
        logic bus_err;
        logic bus_off;
    } cafec_evt_s;

    typedef struct packed {
        cafec_ecnt_t ovf;
        cafec_ecnt_t ovr;
        cafec_ecnt_t berr;
        cafec_ecnt_t boff;
    } cafec_cnt_s;

    typedef struct packed {
        logic [`CAFEC_FLT_W-1:0]                code;
        logic [`CAFEC_FLT_W-1:0]                mask;
        logic                                   xfer_en;
        cafec_frame_s                           hold;
        logic                                   hold_full;
        cafec_frame_s [`CAFEC_FIFO_D-1:0]       fifo;
        cafec_ptr_t                             rd_ptr;
        cafec_ptr_t                             wr_ptr;
        cafec_fcnt_t                            count;
        cafec_cnt_s                             cnt;
        cafec_irq_t                             irq_stat;
        cafec_irq_t                             irq_mask;
        logic [`CAFEC_ST_W-1:0]                 cmd_stat;
        logic [`CAFEC_DATA_W-1:0]               rdata;
        logic                                   ctl_rst;
    } cafec_state_s;

endpackage : cafec_pkg

// ---- cafec_can_node.sv ----
`timescale 1ns/1ns
module cafec_can_node
    import cafec_pkg::*;
(
    input  wire logic   clk_i,
    output cafec_frame_s rx_frame_o,
    output logic        rx_valid_o,
    output cafec_evt_s  evt_o
);
    initial begin
        rx_frame_o = '0;
        rx_valid_o = 1'b0;
        evt_o      = '0;
    end

    // Between frames the lines carry the inverse of the last frame, so stale data cannot pass.
    task automatic send(input logic [10:0] id);
        @(posedge clk_i);
        rx_frame_o <= {id, id[3:0], {4{id[4:0], id}}};
        rx_valid_o <= 1'b1;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_frame_o <= ~{id, id[3:0], {4{id[4:0], id}}};
    endtask : send

    task automatic fault(input logic off);
        @(posedge clk_i);
        evt_o <= {~off, off};
        @(posedge clk_i);
        evt_o <= '0;
    endtask : fault
endmodule : cafec_can_node

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "cafec_map.svh"
module testbench
    import cafec_pkg::*;
;
    logic         clk_i;
    logic         rst_i;
    cafec_bus_s   bus;
    logic [31:0]  rd_data;
    cafec_frame_s frame;
    logic         valid;
    cafec_evt_s   evt;
    logic         irq;
    logic         ctl_rst;
    int           n_errors;
    int           compares;
    int           cycles;
    logic [31:0]  v;
    logic [10:0]  exp_q[$];

    cafec_top uut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rd_data_o(rd_data),
        .rx_frame_i(frame), .rx_valid_i(valid), .evt_i(evt), .irq_o(irq), .ctl_rst_o(ctl_rst));
    cafec_can_node node (.clk_i(clk_i), .rx_frame_o(frame), .rx_valid_o(valid), .evt_o(evt));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // A hang is cut short at 5000 cycles, well beyond the few hundred cycles the tests need.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic cnt_chk(input int ovf, input int ovr, input int berr, input int boff);
        rd(`CAFEC_OFF_CNT_OVF, v);
        chk(v, ovf);
        rd(`CAFEC_OFF_CNT_OVR, v);
        chk(v, ovr);
        rd(`CAFEC_OFF_CNT_BERR, v);
        chk(v, berr);
        rd(`CAFEC_OFF_CNT_BOFF, v);
        chk(v, boff);
    endtask : cnt_chk

    // Pops every expected entry, checking identifier, length and payload in arrival order.
    task automatic drain();
        logic [10:0] e;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            rd(`CAFEC_OFF_RX_STAT, v);
            chk(v[15:0], {e[3:0], 1'b0, e});
            rd(`CAFEC_OFF_RX_DLO, v);
            chk(v, {2{e[4:0], e}});
            rd(`CAFEC_OFF_RX_DHI, v);
            chk(v, {2{e[4:0], e}});
            wr(`CAFEC_OFF_RX_POP, 32'h00000000);
        end
    endtask : drain

    initial begin
        logic [10:0] ids[5];
        ids = '{11'h528, 11'h52F, 11'h538, 11'h728, 11'h4A8};
        n_errors = 0;
        compares = 0;
        cycles = 0;
        bus = '0;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CAFEC_OFF_CODE, v);
        chk(v, 32'h00000000);
        rd(`CAFEC_OFF_MASK, v);
        chk(v, 32'h000000FF);
        cnt_chk(0, 0, 0, 0);
        rd(`CAFEC_OFF_CMD_STAT, v);
        chk(v, 32'h00000000);
        $display("test reset_values done");

        wr(`CAFEC_OFF_CODE, 32'h000000A5);
        wr(`CAFEC_OFF_MASK, 32'h0000000F);
        foreach (ids[i]) begin
            node.send(ids[i]);
            if (((ids[i][10:3] ^ 8'hA5) & 8'hF0) == 8'h00) exp_q.push_back(ids[i]);
        end
        idle(3);
        rd(`CAFEC_OFF_RX_STAT, v);
        chk(v[18:16], 3'h3);
        drain();
        wr(`CAFEC_OFF_RX_POP, 32'h00000000);
        rd(`CAFEC_OFF_CMD_STAT, v);
        chk(v, 32'h00000001);
        rd(8'hFC, v);
        chk(v, 32'h00000000);
        wr(`CAFEC_OFF_RX_STAT, 32'h00000001);
        rd(`CAFEC_OFF_CMD_STAT, v);
        chk(v, 32'h00000002);
        $display("test filter_and_status done");

        for (int k = 0; k < 5; k++) begin
            node.send(11'h528 + 11'(k));
            if (k > 0) exp_q.push_back(11'h528 + 11'(k));
        end
        idle(3);
        rd(`CAFEC_OFF_RX_STAT, v);
        chk(v[18:16], 3'h4);
        cnt_chk(1, 0, 0, 0);
        drain();
        $display("test overflow done");

        wr(`CAFEC_OFF_CTRL, 32'h00000000);
        node.send(11'h52A);
        node.send(11'h52B);
        idle(2);
        rd(`CAFEC_OFF_RX_STAT, v);
        chk(v[19:16], 4'h8);
        cnt_chk(1, 1, 0, 0);
        wr(`CAFEC_OFF_CTRL, 32'h00000001);
        idle(2);
        exp_q.push_back(11'h52B);
        drain();
        $display("test overrun done");

        wr(`CAFEC_OFF_IRQ_MASK, 32'h00000008);
        rd(`CAFEC_OFF_IRQ_STAT, v);
        idle(1);
        chk(irq, 1'b0);
        repeat (3) node.fault(1'b0);
        idle(2);
        chk(irq, 1'b1);
        cnt_chk(1, 1, 3, 0);
        rd(`CAFEC_OFF_IRQ_STAT, v);
        chk(v[3], 1'b1);
        idle(1);
        chk(irq, 1'b0);
        $display("test bus_error done");

        wr(`CAFEC_OFF_CTRL, 32'h00000000);
        node.send(11'h52C);
        idle(2);
        node.fault(1'b1);
        #1;
        chk(ctl_rst, 1'b1);
        idle(1);
        chk(ctl_rst, 1'b0);
        rd(`CAFEC_OFF_RX_STAT, v);
        chk(v[19], 1'b0);
        cnt_chk(1, 1, 3, 1);
        rd(`CAFEC_OFF_IRQ_STAT, v);
        chk(v, 32'h00000010);
        $display("test bus_off done");

        wr(`CAFEC_OFF_CTRL, 32'h00000001);
        wr(`CAFEC_OFF_MASK, 32'h00000000);
        wr(`CAFEC_OFF_CNT_OVF, 32'h00000001);
        rd(`CAFEC_OFF_CMD_STAT, v);
        chk(v, 32'h00000002);
        node.send(11'h52D);
        node.send(11'h530);
        idle(3);
        exp_q.push_back(11'h52D);
        drain();
        rd(`CAFEC_OFF_RX_STAT, v);
        chk(v[18:16], 3'h0);
        cnt_chk(1, 1, 3, 1);
        $display("test exact_mask done");

        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cnt_chk(0, 0, 0, 0);
        node.send(11'h0F3);
        idle(3);
        exp_q.push_back(11'h0F3);
        drain();
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule : testbench
